// ---- core/nvram_ctl.sv ----
// store and recall controller of a sixteen-word serial nvram
`timescale 1ns/10ps
`include "nvram_ctl_cfg.svh"
module nvram_ctl
  import nvram_ctl_pkg::*;
#(
  parameter int STORE_CYC = `NV_STORE_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // hardware strobes, active low
  input  wire logic        store_n,
  input  wire logic        recall_n,
  // serial port
  input  wire logic        serial_shift_clock,
  input  wire logic        serial_input_line,
  input  wire logic        chip_sel_n,
  // supply detector, high while supply is low
  input  wire logic        supply_low,
  // status
  output logic             busy,
  output logic             wr_en_latch,
  output logic             prev_recall_latch,
  output logic [255:0]     ram_image,
  output logic [255:0]     ee_image
);
  localparam int W = `NV_WIDTH;
  localparam int N = `NV_WORDS;
  localparam logic [4:0] STP_C = 5'(`NV_STP_CYC);
  localparam logic [4:0] RCP_C = 5'(`NV_RCP_CYC);
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // two-flop synchronisers: store, recall, sk, di, select, supply
  logic [5:0] s1_q, s2_q;
  logic       sk_prev_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // idle levels: supply taken as low, deselected, both strobes high
      s1_q <= 6'h33;
      s2_q <= 6'h33;
      sk_prev_q <= 1'b0;
    end else begin
      s1_q <= {supply_low, chip_sel_n, serial_input_line, serial_shift_clock,
               recall_n, store_n};
      s2_q <= s1_q;
      sk_prev_q <= s2_q[2];
    end
  end
  wire st_pin  = ~s2_q[0] & s2_q[1];
  wire rc_pin  = ~s2_q[1] & s2_q[0];
  wire sk_rise = s2_q[2] & ~sk_prev_q;
  wire lowv    = s2_q[5];

  shift_if sif ();
  serial_rx u_rx (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .sk_rise (sk_rise),
    .sel     (~s2_q[4] & s2_q[1] & s2_q[0]),
    .din     (s2_q[3]),
    .sif     (sif)
  );

  logic [W-1:0] ram_q [N];
  logic [W-1:0] ee_q  [N];

  typedef struct packed {
    op_state_t  st;
    logic [4:0] stp;
    logic [4:0] rcp;
    logic [23:0] tmr;
    logic       wel;
    logic       prl;
    logic       boot;
    logic       busy;
  } ctl_state_t;
  ctl_state_t c_q, c_d;

  wire [2:0] op     = sif.instr[2:0];
  wire       sw_st  = sif.valid && op == `NV_OP_STORE;
  wire       sw_rc  = sif.valid && op == `NV_OP_RECALL;
  wire       hw_st  = c_q.stp >= STP_C;
  wire       hw_rc  = c_q.rcp >= RCP_C;
  wire       st_req = (hw_st || sw_st) && !lowv && c_q.wel && c_q.prl;
  wire       wr_req = sif.valid && op == `NV_OP_WRITE && c_q.wel && c_q.prl;

  always_comb begin
    c_d = c_q;
    c_d.stp = st_pin ? (hw_st ? c_q.stp : c_q.stp + 5'h01) : 5'h00;
    c_d.rcp = rc_pin ? (hw_rc ? c_q.rcp : c_q.rcp + 5'h01) : 5'h00;
    if (lowv) begin
      c_d.wel = 1'b0;
    end
    case (c_q.st)
      ST_IDLE: begin
        if (c_q.boot) begin
          c_d.boot = 1'b0;
          c_d.st = ST_RECALL;
        end else if (st_req) begin
          c_d.st = ST_STORE;
          c_d.tmr = 24'(STORE_CYC);
        end else if (hw_rc || sw_rc) begin
          c_d.st = ST_RECALL;
        end else if (sif.valid && op == `NV_OP_WREN && !lowv) begin
          c_d.wel = 1'b1;
        end else if (sif.valid && op == `NV_OP_WRDS) begin
          c_d.wel = 1'b0;
        end
      end
      ST_STORE: begin
        if (c_q.tmr <= 24'h1) begin
          c_d.st = ST_IDLE;
          c_d.wel = 1'b0;
        end else begin
          c_d.tmr = c_q.tmr - 24'h1;
        end
      end
      ST_RECALL: begin
        c_d.st = ST_IDLE;
        c_d.prl = 1'b1;
      end
      default: c_d.st = ST_IDLE;
    endcase
    c_d.busy = c_d.st != ST_IDLE;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c_q <= '{st: ST_IDLE, stp: 5'h00, rcp: 5'h00, tmr: 24'h000000, wel: 1'b0,
               prl: 1'b0, boot: 1'b1, busy: 1'b0};
    end else begin
      c_q <= c_d;
    end
  end

  // array transfers; ram writes blocked during store
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_word
      always_ff @(posedge mclk) begin
        if (c_q.st == ST_STORE && c_d.st == ST_IDLE) begin
          ee_q[i] <= ram_q[i];
        end
        if (c_q.st == ST_RECALL) begin
          ram_q[i] <= ee_q[i];
        end else if (c_q.st == ST_IDLE && !st_req && wr_req &&
                     sif.instr[6:3] == 4'(i)) begin
          ram_q[i] <= sif.data;
        end
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          ram_image[i*W +: W] <= 16'h0000;
          ee_image[i*W +: W]  <= 16'h0000;
        end else begin
          ram_image[i*W +: W] <= ram_q[i];
          ee_image[i*W +: W]  <= ee_q[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      wr_en_latch <= 1'b0;
      prev_recall_latch <= 1'b0;
    end else begin
      busy <= c_d.busy;
      wr_en_latch <= c_d.wel;
      prev_recall_latch <= c_d.prl;
    end
  end
endmodule

// ---- core/nvram_ctl_cfg.svh ----
// constants for the serial nvram store and recall controller
`ifndef NVRAM_CTL_CFG_SVH
`define NVRAM_CTL_CFG_SVH
`define NV_WORDS        16
`define NV_WIDTH        16
`define NV_AW           4
`define NV_OP_WRDS      3'h0
`define NV_OP_STORE     3'h1
`define NV_OP_WREN      3'h4
`define NV_OP_RECALL    3'h5
`define NV_OP_WRITE     3'h3
`define NV_CLK_MHZ      25
`define NV_STP_NS       200
`define NV_RCP_NS       500
`define NV_STP_CYC      ((`NV_STP_NS * `NV_CLK_MHZ + 999) / 1000)
`define NV_RCP_CYC      ((`NV_RCP_NS * `NV_CLK_MHZ + 999) / 1000)
`define NV_STORE_MS     10
`define NV_STORE_CYC    (`NV_STORE_MS * `NV_CLK_MHZ * 1000)
`endif

// ---- core/nvram_ctl_pkg.sv ----
// types for the serial nvram store and recall controller
package nvram_ctl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_STORE, ST_RECALL} op_state_t;
endpackage

// ---- core/shift_if.sv ----
// instruction hand-off from serial receiver to controller
`timescale 1ns/10ps
interface shift_if;
  logic       valid;
  logic [7:0] instr;
  logic [15:0] data;
  modport rx   (output valid, output instr, output data);
  modport ctl  (input valid, input instr, input data);
endinterface

// ---- core/serial_rx.sv ----
// serial receiver: gathers instructions and write data on shift clock rising edges
`timescale 1ns/10ps
`include "nvram_ctl_cfg.svh"
module serial_rx
  import nvram_ctl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // shift clock edge, select and data
  input wire logic sk_rise,
  input wire logic sel,
  input wire logic din,
  // instruction hand-off
  shift_if.rx      sif
);
  typedef struct packed {
    logic [4:0]  cnt;
    logic [7:0]  instr;
    logic [15:0] data;
    logic        valid;
  } rx_state_t;
  rx_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    if (!sel) begin
      s_d.cnt = 5'h00;
    end else if (sk_rise) begin
      if (s_q.cnt == 5'h00) begin
        if (din) begin
          s_d.instr = 8'h01;
          s_d.cnt = 5'h01;
        end
      end else if (s_q.cnt < 5'h08) begin
        s_d.instr = {s_q.instr[6:0], din};
        s_d.cnt = s_q.cnt + 5'h01;
        if (s_q.cnt == 5'h07 && s_q.instr[1:0] != 2'h1) begin
          s_d.valid = 1'b1;
          s_d.cnt = 5'h1F;
        end
      end else if (s_q.cnt < 5'h18) begin
        s_d.data = {s_q.data[14:0], din};
        s_d.cnt = s_q.cnt + 5'h01;
        if (s_q.cnt == 5'h17) begin
          s_d.valid = 1'b1;
          s_d.cnt = 5'h1F;
        end
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign sif.valid = s_q.valid;
  assign sif.instr = s_q.instr;
  assign sif.data  = s_q.data;
endmodule

// ---- verification/nvram_ctl_monitor.sv ----
// assertion checker for the nvram store and recall controller
`timescale 1ns/10ps
module nvram_ctl_monitor #(
  parameter int STORE_CYC = 20
) (
  // clock and reset
  input wire logic         mclk,
  input wire logic         rstn,
  // strobes, serial port, supply
  input wire logic         store_n,
  input wire logic         recall_n,
  input wire logic         serial_shift_clock,
  input wire logic         serial_input_line,
  input wire logic         chip_sel_n,
  input wire logic         supply_low,
  // status
  input wire logic         busy,
  input wire logic         wr_en_latch,
  input wire logic         prev_recall_latch,
  input wire logic [255:0] ram_image,
  input wire logic [255:0] ee_image
);
  int run_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) run_q <= 0;
    else run_q <= busy ? run_q + 1 : 0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_auto;
    $rose(rstn) |-> ##[1:8] prev_recall_latch;
  endproperty
  a_auto: assert property (p_auto) else $error("no recall after reset");
  // the images are registered copies, so they settle one cycle after busy drops
  property p_st_end;
    $fell(busy) && run_q > 1 |-> !wr_en_latch ##1 (ee_image === ram_image);
  endproperty
  a_st_end: assert property (p_st_end) else $error("store end wrong");
  property p_rc_end;
    $fell(busy) && run_q == 1 |-> prev_recall_latch ##1 (ram_image === ee_image);
  endproperty
  a_rc_end: assert property (p_rc_end) else $error("recall end wrong");
  property p_len;
    $fell(busy) |-> run_q == 1 || run_q == STORE_CYC;
  endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_gate;
    $rose(busy) ##1 busy |-> wr_en_latch && prev_recall_latch;
  endproperty
  a_gate: assert property (p_gate) else $error("store without latches");
  property p_low;
    supply_low [*6] |-> !wr_en_latch;
  endproperty
  a_low: assert property (p_low) else $error("latch kept at low supply");
  property p_hold;
    busy && $past(busy) |-> $stable(ram_image);
  endproperty
  a_hold: assert property (p_hold) else $error("ram moved during store");
  property p_idle;
    (store_n && recall_n && chip_sel_n && prev_recall_latch) [*8] |-> !$rose(busy);
  endproperty
  a_idle: assert property (p_idle) else $error("operation without request");
  c_store: cover property ($rose(busy) ##1 busy);
  c_recall: cover property ($rose(busy) ##1 !busy);
  c_low: cover property (supply_low && wr_en_latch);
endmodule
bind nvram_ctl nvram_ctl_monitor #(.STORE_CYC(STORE_CYC)) mon (
  .mclk(mclk), .rstn(rstn), .store_n(store_n), .recall_n(recall_n),
  .serial_shift_clock(serial_shift_clock), .serial_input_line(serial_input_line),
  .chip_sel_n(chip_sel_n), .supply_low(supply_low), .busy(busy), .wr_en_latch(wr_en_latch),
  .prev_recall_latch(prev_recall_latch), .ram_image(ram_image), .ee_image(ee_image));

// ---- verification/nvram_host.sv ----
// host model: drives the strobes and the serial port of the controller
`timescale 1ns/10ps
module nvram_host (
  // clock
  input wire logic mclk,
  // strobes and serial port
  output logic     store_n,
  output logic     recall_n,
  output logic     sk,
  output logic     din,
  output logic     cs_n
);
  initial {store_n, recall_n, sk, din, cs_n} = 5'h19;
  // shift clock idles low between frames; released data line shows the inverse
  // nb bits are shifted; fewer than eight make a cut frame
  task automatic frame(input logic [7:0] ins, input logic [15:0] dat, input int nb);
    logic [23:0] sh;
    sh = {ins, dat};
    cs_n = 1'b0;
    repeat (20) @(negedge mclk);
    for (int i = 0; i < nb; i++) begin
      din = sh[23 - i];
      repeat (4) @(negedge mclk);
      sk = 1'b1;
      repeat (4) @(negedge mclk);
      sk = 1'b0;
    end
    repeat (10) @(negedge mclk);
    cs_n = 1'b1;
    din = ~din;
    repeat (20) @(negedge mclk);
  endtask
  task automatic strobe(input bit st, input int cyc);
    if (st) store_n = 1'b0;
    else recall_n = 1'b0;
    repeat (cyc) @(negedge mclk);
    store_n = 1'b1;
    recall_n = 1'b1;
  endtask
endmodule

// ---- verification/serial_nvram_store_recall_control_tb.sv ----
// self-checking bench for the nvram store and recall controller
`timescale 1ns/10ps
module serial_nvram_store_recall_control_tb;
  logic mclk, rstn, supply_low, store_n, recall_n, sk, din, cs_n;
  logic busy, wr_en_latch, prev_recall_latch;
  logic [255:0] ram_image, ee_image, ram_x, ee_x;
  logic [15:0] rows [16];
  int error_cnt, comparisons;
  nvram_ctl #(.STORE_CYC(20)) dut (.mclk(mclk), .rstn(rstn), .store_n(store_n),
    .recall_n(recall_n), .serial_shift_clock(sk), .serial_input_line(din), .chip_sel_n(cs_n),
    .supply_low(supply_low), .busy(busy), .wr_en_latch(wr_en_latch),
    .prev_recall_latch(prev_recall_latch), .ram_image(ram_image), .ee_image(ee_image));
  nvram_host host (.mclk(mclk), .store_n(store_n), .recall_n(recall_n), .sk(sk), .din(din),
    .cs_n(cs_n));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic settle;
    int n;
    repeat (30) @(negedge mclk);
    for (n = 0; n < 200 && busy !== 1'b0; n++) @(negedge mclk);
    if (n == 200) begin
      error_cnt++;
      final_report;
    end
  endtask
  task automatic op(input logic [7:0] ins);
    host.frame(ins, 16'h0000, 8);
    settle;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    host.frame({1'b1, a, 3'h3}, d, 24);
    ram_x[16 * a +: 16] = d;
  endtask
  initial begin
    rstn = 1'b0;
    supply_low = 1'b0;
    for (int i = 0; i < 16; i++) rows[i] = 16'hA55A ^ (16'h1111 * 16'(i));
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    repeat (20) @(negedge mclk);
    chk("prev_recall", prev_recall_latch, 1'b1);
    chk("wren_reset", wr_en_latch, 1'b0);
    op(8'h84);
    for (int i = 0; i < 16; i++) begin
      wr(4'(i), rows[i]);
      chk("ram_word", ram_image[16 * i +: 16], rows[i]);
    end
    op(8'h81);
    ee_x = ram_x;
    chk("ee_sw_store", ee_image, ee_x);
    chk("wren_after_store", wr_en_latch, 1'b0);
    op(8'h84);
    wr(4'h0, 16'h1234);
    op(8'h80);
    host.strobe(1'b1, 8);
    settle;
    chk("ee_no_wren", ee_image, ee_x);
    op(8'h84);
    supply_low = 1'b1;
    repeat (10) @(negedge mclk);
    host.strobe(1'b1, 8);
    settle;
    chk("ee_low_supply", ee_image, ee_x);
    chk("wren_low_supply", wr_en_latch, 1'b0);
    supply_low = 1'b0;
    op(8'h84);
    host.strobe(1'b1, 8);
    repeat (4) @(negedge mclk);
    chk("busy_hw_store", busy, 1'b1);
    settle;
    ee_x = ram_x;
    chk("ee_hw_store", ee_image, ee_x);
    op(8'h84);
    wr(4'h1, 16'h00FF);
    host.strobe(1'b0, 16);
    settle;
    chk("ram_hw_recall", ram_image, ee_x);
    ram_x = ee_x;
    wr(4'h3, 16'h0F0F);
    op(8'h85);
    chk("ram_sw_recall", ram_image, ee_x);
    ram_x = ee_x;
    // store instruction cut after five bits must not run
    wr(4'h2, 16'hBEEF);
    host.frame(8'h81, 16'h0000, 5);
    settle;
    chk("ee_cut_frame", ee_image, ee_x);
    // reset in mid-run: arrays keep their contents, boot recall restores ram
    rstn = 1'b0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    repeat (20) @(negedge mclk);
    chk("ram_boot_recall", ram_image, ee_x);
    chk("prev_recall_again", prev_recall_latch, 1'b1);
    chk("wren_mid_reset", wr_en_latch, 1'b0);
    final_report;
  end
endmodule
